/* design/sst_cfg.svh */
// Offsets, field positions, reset values and timing counts of the sense unit.
`ifndef SST_CFG_SVH
`define SST_CFG_SVH
`define SST_CLK_MHZ         50
`define SST_SELFTEST_US     10
`define SST_SELFTEST_CYC    (`SST_SELFTEST_US * `SST_CLK_MHZ)
`define SST_OFF_CTRL        8'h00
`define SST_OFF_STAT        8'h04
`define SST_OFF_MASK        8'h08
`define SST_OFF_SUMMARY     8'h0C
`define SST_OFF_SENSE       8'h40
`define SST_SENSE_BYTES     18
`define SST_CTRL_DFEN_BIT   0
`define SST_STAT_SENSE_BIT  0
`define SST_STAT_DIAG_BIT   1
`define SST_STAT_WEND_BIT   2
`define SST_STAT_W          3
`define SST_CTRL_RST        1'b0
`define SST_MASK_RST        3'b000
`define SST_RESP_CODE       8'hF0
`define SST_ADD_LEN         8'h0A
`define SST_OP_SENDDIAG     8'h1D
`define SST_EOM_BIT         6
`define SST_ILI_BIT         5
`endif

/* design/sst_pkg.sv */
// Types shared by the sense and self-test unit.
`default_nettype none
package sst_pkg;
  typedef enum logic [4:0] {
    SST_C_NOTREADY  = 5'h00, SST_C_INTERLOCK = 5'h01, SST_C_JAM     = 5'h02,
    SST_C_COVER     = 5'h03, SST_C_NOPAPER   = 5'h04, SST_C_SEPSHEET = 5'h05,
    SST_C_ROLLER    = 5'h06, SST_C_HEADCHK   = 5'h07, SST_C_INTFAIL  = 5'h08,
    SST_C_FBFUSE    = 5'h09, SST_C_HEATFUSE  = 5'h0A, SST_C_LAMPFUSE = 5'h0B,
    SST_C_ADFFUSE   = 5'h0C, SST_C_MECH      = 5'h0D, SST_C_OPTIC    = 5'h0E,
    SST_C_ENDFAIL   = 5'h0F, SST_C_ENDFUSE   = 5'h10, SST_C_BADOP    = 5'h11,
    SST_C_BADCDB    = 5'h12, SST_C_BADLUN    = 5'h13, SST_C_BADPARM  = 5'h14,
    SST_C_BADWIN    = 5'h15, SST_C_UNITATTN  = 5'h16, SST_C_PARITY   = 5'h17,
    SST_C_XFER      = 5'h18
  } sst_cond_t;
  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } sst_code_t;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  flags;
    logic [15:0] paramLen;
  } sst_cdb_t;
  typedef enum logic [1:0] {
    SST_D_IDLE = 2'b00, SST_D_RUN = 2'b01, SST_D_DONE = 2'b10
  } sst_diag_t;
endpackage
`default_nettype wire

/* design/sst_sense_unit.sv */
// Sense data builder, condition mapper and self-test sequencer.
//
// What this block does
// - Information field zero, else requested minus delivered.
// - Additional sense length always ten bytes.
// - Command-specific information always zero.
// - Replaceable-unit and key-specific bytes zero.
// - Not-ready codes 00/00 and 80/01.
// - Medium error 80h qualifiers per cause.
// - Hardware error codes 44h and 80h qualifiers.
// - Illegal request codes 20,24,25,26,2C/02.
// - Enabled double feed reported as jam.
// - Send diagnostic: default self test, zero length.
// - Self test: GOOD on pass, hardware error else.
// - Page-format and offline bits are ignored.
// - Unit attention after reset; aborted-command codes.
// - End-of-medium set when window reading ends.
`include "sst_cfg.svh"
`default_nettype none
module sst_sense_unit
  import sst_pkg::*;
#(
  parameter int SELFTEST_CYC = `SST_SELFTEST_CYC
) (
  input  wire logic        sys_clk,     // System clock, 50 MHz.
  input  wire logic        rst,         // Synchronous reset, active high.
  input  wire logic [7:0]  regAddr,     // Register byte address.
  input  wire logic [31:0] regWdata,    // Register write data.
  input  wire logic        regWr,       // Write strobe.
  input  wire logic        regRd,       // Read strobe.
  output logic      [31:0] regRdata,    // Read data, cycle after strobe.
  input  wire logic        condValid,   // Error condition pulse.
  input  wire sst_cond_t   condCode,    // Which condition.
  input  wire logic        readDone,    // Read command finished pulse.
  input  wire logic [31:0] reqLen,      // Requested transfer length.
  input  wire logic [31:0] actLen,      // Bytes actually delivered.
  input  wire logic        windowEnd,   // Window read complete pulse.
  input  wire logic        cdbValid,    // Command block present pulse.
  input  wire sst_cdb_t    cdb,         // Command block fields.
  input  wire logic        hwFault,     // Self-test fault level.
  input  wire logic        dblFeedPin,  // Double-feed sensor pin.
  input  wire logic        interlockPin, // Interlock open pin.
  output logic             diagDone,    // Diagnostic finished pulse.
  output logic             diagCheck,   // CHECK CONDITION with diagDone.
  output logic             irq          // Level interrupt.
);
  initial begin
    if (SELFTEST_CYC < 1) $error("SELFTEST_CYC must be at least 1");
  end

  // Sense code of each reportable condition.
  function automatic sst_code_t condMap(input sst_cond_t c);
    unique case (c)
      SST_C_NOTREADY:  condMap = '{4'h2, 8'h00, 8'h00};
      SST_C_INTERLOCK: condMap = '{4'h2, 8'h80, 8'h01};
      SST_C_JAM:       condMap = '{4'h3, 8'h80, 8'h01};
      SST_C_COVER:     condMap = '{4'h3, 8'h80, 8'h02};
      SST_C_NOPAPER:   condMap = '{4'h3, 8'h80, 8'h03};
      SST_C_SEPSHEET:  condMap = '{4'h3, 8'h80, 8'h04};
      SST_C_ROLLER:    condMap = '{4'h3, 8'h80, 8'h08};
      SST_C_HEADCHK:   condMap = '{4'h3, 8'h80, 8'h10};
      SST_C_INTFAIL:   condMap = '{4'h4, 8'h44, 8'h00};
      SST_C_FBFUSE:    condMap = '{4'h4, 8'h80, 8'h01};
      SST_C_HEATFUSE:  condMap = '{4'h4, 8'h80, 8'h02};
      SST_C_LAMPFUSE:  condMap = '{4'h4, 8'h80, 8'h03};
      SST_C_ADFFUSE:   condMap = '{4'h4, 8'h80, 8'h04};
      SST_C_MECH:      condMap = '{4'h4, 8'h80, 8'h05};
      SST_C_OPTIC:     condMap = '{4'h4, 8'h80, 8'h06};
      SST_C_ENDFAIL:   condMap = '{4'h4, 8'h80, 8'h10};
      SST_C_ENDFUSE:   condMap = '{4'h4, 8'h80, 8'h11};
      SST_C_BADOP:     condMap = '{4'h5, 8'h20, 8'h00};
      SST_C_BADCDB:    condMap = '{4'h5, 8'h24, 8'h00};
      SST_C_BADLUN:    condMap = '{4'h5, 8'h25, 8'h00};
      SST_C_BADPARM:   condMap = '{4'h5, 8'h26, 8'h00};
      SST_C_BADWIN:    condMap = '{4'h5, 8'h2C, 8'h02};
      SST_C_UNITATTN:  condMap = '{4'h6, 8'h00, 8'h00};
      SST_C_PARITY:    condMap = '{4'hB, 8'h47, 8'h00};
      SST_C_XFER:      condMap = '{4'hB, 8'h80, 8'h01};
      default:         condMap = '{4'h0, 8'h00, 8'h00};
    endcase
  endfunction

  // Pin synchronisers; the second stage is read, and on the interlock path ilPrev as well, for edge detection.
  logic dfMeta, dfSync, ilMeta, ilSync, ilPrev;
  always_ff @(posedge sys_clk) begin
    dfMeta <= dblFeedPin;
    dfSync <= dfMeta;
    ilMeta <= interlockPin;
    ilSync <= ilMeta;
    ilPrev <= rst ? 1'b0 : ilSync;
  end

  // Register file.
  logic                   dblFeedEn;
  logic [`SST_STAT_W-1:0] stat, mask;
  wire  wrCtrl = regWr && regAddr == `SST_OFF_CTRL;
  wire  wrMask = regWr && regAddr == `SST_OFF_MASK;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dblFeedEn <= `SST_CTRL_RST;
      mask      <= `SST_MASK_RST;
    end else begin
      if (wrCtrl) dblFeedEn <= regWdata[`SST_CTRL_DFEN_BIT];
      if (wrMask) mask <= regWdata[`SST_STAT_W-1:0];
    end
  end

  // Self-test sequencer.
  sst_diag_t diagState;
  logic [$clog2(SELFTEST_CYC+1)-1:0] diagCnt;
  // Flag bits PF, DevOfL and UnitOfL are never examined here.
  wire isDiag  = cdbValid && cdb.opcode == `SST_OP_SENDDIAG;
  wire diagOk  = cdb.flags[2] && cdb.paramLen == 16'h0000;
  wire diagBad = isDiag && !diagOk && diagState == SST_D_IDLE;
  wire diagEnd = diagState == SST_D_RUN && diagCnt == '0;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      diagState <= SST_D_IDLE;
      diagCnt   <= '0;
    end else begin
      unique case (diagState)
        SST_D_IDLE: begin
          if (isDiag && diagOk) begin
            diagState <= SST_D_RUN;
            diagCnt   <= ($clog2(SELFTEST_CYC+1))'(SELFTEST_CYC - 1);
          end
        end
        SST_D_RUN: begin
          if (diagEnd) diagState <= SST_D_DONE;
          else diagCnt <= diagCnt - 1'b1;
        end
        SST_D_DONE: diagState <= SST_D_IDLE;
      endcase
    end
  end

  // A fault sampled at the end of the test sets hardware-error sense.
  logic faultSeen;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      diagDone  <= 1'b0;
      diagCheck <= 1'b0;
      faultSeen <= 1'b0;
    end else begin
      diagDone  <= diagEnd || diagBad;
      diagCheck <= (diagEnd && hwFault) || diagBad;
      faultSeen <= diagEnd && hwFault;
    end
  end

  // Sense state. The newest event wins; a posting beats the read-clear.
  sst_code_t  sense;
  logic       ili, eom, validPost;
  logic [31:0] info;
  wire sst_cond_t evCode =
      (diagEnd && hwFault)            ? SST_C_INTFAIL :
      diagBad                         ? SST_C_BADCDB  :
      (ilSync && !ilPrev)             ? SST_C_INTERLOCK :
      (dfSync && dblFeedEn)           ? SST_C_JAM     :
      condCode;
  wire evHit = (diagEnd && hwFault) || diagBad || (ilSync && !ilPrev) ||
               (dfSync && dblFeedEn) || condValid;
  wire sumRd  = regRd && regAddr == `SST_OFF_SUMMARY;
  wire lastRd = regRd && regAddr ==
                8'(`SST_OFF_SENSE + 4 * (`SST_SENSE_BYTES - 1));
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense     <= condMap(SST_C_UNITATTN);
      validPost <= 1'b1;
      ili       <= 1'b0;
      eom       <= 1'b0;
      info      <= 32'h0000_0000;
    end else begin
      if (evHit) begin
        sense     <= condMap(evCode);
        validPost <= 1'b1;
      end else if (lastRd) begin
        sense     <= condMap(SST_C_NOTREADY) & '0;
        validPost <= 1'b0;
      end
      if (readDone) begin
        ili  <= reqLen != actLen;
        info <= (reqLen != actLen) ? reqLen - actLen : 32'h0000_0000;
      end else if (lastRd) begin
        ili  <= 1'b0;
        info <= 32'h0000_0000;
      end
      if (windowEnd) eom <= 1'b1;
      else if (lastRd) eom <= 1'b0;
    end
  end

  // Fixed-format sense bytes.
  function automatic logic [7:0] senseByte(input logic [4:0] i);
    unique case (i)
      5'd0:  senseByte = `SST_RESP_CODE;
      5'd2:  senseByte = {1'b0, eom, ili, 1'b0, sense.key};
      5'd3:  senseByte = info[31:24];
      5'd4:  senseByte = info[23:16];
      5'd5:  senseByte = info[15:8];
      5'd6:  senseByte = info[7:0];
      5'd7:  senseByte = `SST_ADD_LEN;
      5'd12: senseByte = sense.asc;
      5'd13: senseByte = sense.ascq;
      default: senseByte = 8'h00;
    endcase
  endfunction

  // Interrupt status: read clears, a same-cycle set wins.
  wire statRd = regRd && regAddr == `SST_OFF_STAT;
  logic [`SST_STAT_W-1:0] evBits;
  assign evBits = {windowEnd, diagDone, evHit};
  always_ff @(posedge sys_clk) begin
    if (rst) stat <= '0;
    else stat <= (statRd ? '0 : stat) | evBits;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) irq <= 1'b0;
    else irq <= |(stat & mask);
  end

  // Read port.
  wire [7:0] senseOff = regAddr - `SST_OFF_SENSE;
  always_ff @(posedge sys_clk) begin
    if (rst) regRdata <= 32'h0000_0000;
    else if (!regRd) regRdata <= 32'h0000_0000;
    else if (regAddr >= `SST_OFF_SENSE && senseOff[1:0] == 2'b00 &&
             senseOff[7:2] < 6'(`SST_SENSE_BYTES))
      regRdata <= {24'h00_0000, senseByte(senseOff[6:2])};
    else begin
      unique case (regAddr)
        `SST_OFF_CTRL:    regRdata <= {31'h0, dblFeedEn};
        `SST_OFF_STAT:    regRdata <= {29'h0, stat};
        `SST_OFF_MASK:    regRdata <= {29'h0, mask};
        `SST_OFF_SUMMARY: regRdata <= {7'h0, validPost, 2'b00, eom, ili,
                                       sense.key, sense.asc, sense.ascq};
        default:          regRdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks.
  sequence sDiagStart;
    isDiag && diagOk && diagState == SST_D_IDLE;
  endsequence
  sequence sDiagFail;
    diagEnd && hwFault;
  endsequence

  a_info_diff: assert property (@(posedge sys_clk) disable iff (rst)
    readDone && !lastRd |=> info == $past(reqLen) - $past(actLen))
    else $error("information field mismatch");
  a_addlen_fixed: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr == 8'h5C |=> regRdata == 32'h0000_000A)
    else $error("additional sense length not ten");
  a_cmdspec_zero: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr inside {8'h60, 8'h64, 8'h68, 8'h6C} |=> regRdata == 0)
    else $error("command-specific bytes not zero");
  a_fru_zero: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr inside {8'h78, 8'h7C, 8'h80, 8'h84} |=> regRdata == 0)
    else $error("unit code or key-specific byte not zero");
  a_interlock_code: assert property (@(posedge sys_clk) disable iff (rst)
    ilSync && !ilPrev |=> sense == '{4'h2, 8'h80, 8'h01})
    else $error("interlock sense wrong");
  a_jam_double: assert property (@(posedge sys_clk) disable iff (rst)
    dfSync && dblFeedEn && !(ilSync && !ilPrev) && !diagEnd && !diagBad
    |=> sense == '{4'h3, 8'h80, 8'h01})
    else $error("double feed not reported as jam");
  // The run length is carried by diagCnt, so no long delay is unrolled.
  a_diag_start: assert property (@(posedge sys_clk) disable iff (rst)
    sDiagStart |=> diagState == SST_D_RUN && diagCnt == SELFTEST_CYC - 1)
    else $error("self test did not start with full count");
  a_diag_pass: assert property (@(posedge sys_clk) disable iff (rst)
    diagEnd && !hwFault |=> diagDone && !diagCheck)
    else $error("passing self test not ended with good status");
  a_diag_fail: assert property (@(posedge sys_clk) disable iff (rst)
    sDiagFail |=> diagCheck && diagDone && sense.key == 4'h4)
    else $error("self-test failure not hardware error");
  a_bad_diag: assert property (@(posedge sys_clk) disable iff (rst)
    diagBad |=> diagDone && diagCheck && sense.asc == 8'h24)
    else $error("bad diagnostic block not refused");
  a_eom_set: assert property (@(posedge sys_clk) disable iff (rst)
    windowEnd |=> eom)
    else $error("end of medium not set");
  a_ua_reset: assert property (@(posedge sys_clk)
    $fell(rst) |-> sense == '{4'h6, 8'h00, 8'h00})
    else $error("unit attention missing after reset");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 irq == $past(|(stat & mask)))
    else $error("interrupt does not follow status");
endmodule // sst_sense_unit
`default_nettype wire

/* verification/sst_initiator_model.sv */
// Behavioural initiator that issues send-diagnostic command blocks.
`include "sst_cfg.svh"
`default_nettype none
module sst_initiator_model
  import sst_pkg::*;
(
  input  wire logic        sys_clk,   // System clock.
  input  wire logic        rst,       // Synchronous reset, active high.
  input  wire logic        sendReq,   // Issue one command block.
  input  wire logic        selfTest,  // Self-test bit to send.
  input  wire logic        pageFmt,   // Page-format bit to send.
  input  wire logic        offLine,   // Both offline bits to send.
  input  wire logic [15:0] listLen,   // Parameter list length to send.
  output logic             cdbValid,  // Command block present pulse.
  output sst_cdb_t         cdb        // Command block fields.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Once released, the block fields toggle so stale values cannot be reused.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cdbValid <= 1'b0;
      cdb      <= '0;
    end else if (sendReq) begin
      cdbValid     <= 1'b1;
      cdb.opcode   <= `SST_OP_SENDDIAG;
      cdb.flags    <= {3'h0, pageFmt, 1'b0, selfTest, offLine, offLine};
      cdb.paramLen <= listLen;
    end else begin
      cdbValid <= 1'b0;
      cdb      <= ~cdb;
    end
  end
endmodule // sst_initiator_model
`default_nettype wire

/* verification/scsi_sense_and_selftest_bench.sv */
// Self-checking bench for the sense and self-test unit.
`include "sst_cfg.svh"
`default_nettype none
module scsi_sense_and_selftest_bench
  import sst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STC = 4;
  logic        sys_clk, rst, regWr, regRd, condValid, readDone, windowEnd;
  logic        cdbValid, hwFault, dblFeedPin, interlockPin, diagDone;
  logic        diagCheck, irq, sendReq, selfTest, pageFmt, offLine;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, reqLen, actLen, got;
  logic [15:0] listLen;
  sst_cond_t   condCode;
  sst_cdb_t    cdb;
  int          fails, cmpCount;
  logic [19:0] codeTbl [25] = '{20'h2_0000, 20'h2_8001, 20'h3_8001,
    20'h3_8002, 20'h3_8003, 20'h3_8004, 20'h3_8008, 20'h3_8010, 20'h4_4400,
    20'h4_8001, 20'h4_8002, 20'h4_8003, 20'h4_8004, 20'h4_8005, 20'h4_8006,
    20'h4_8010, 20'h4_8011, 20'h5_2000, 20'h5_2400, 20'h5_2500, 20'h5_2600,
    20'h5_2C02, 20'h6_0000, 20'hB_4700, 20'hB_8001};
  logic [31:0] lenA [3] = '{32'h0000_0064, 32'h0000_0028, 32'h0000_0007};
  logic [31:0] lenB [3] = '{32'h0000_0028, 32'h0000_0064, 32'h0000_0007};

  sst_sense_unit #(.SELFTEST_CYC(STC)) u_dut (.sys_clk, .rst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .condValid, .condCode, .readDone,
    .reqLen, .actLen, .windowEnd, .cdbValid, .cdb, .hwFault, .dblFeedPin,
    .interlockPin, .diagDone, .diagCheck, .irq);
  sst_initiator_model u_init (.sys_clk, .rst, .sendReq, .selfTest, .pageFmt,
    .offLine, .listLen, .cdbValid, .cdb);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rdck(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  // Reading the last byte clears the sense, so every call ends with it.
  task automatic senseCk(input logic [3:0] key, input logic [7:0] asc, ascq,
                         input logic eom, ili, input logic [31:0] info);
    logic [7:0] e [18];
    e = '{default: 8'h00};
    e[0] = `SST_RESP_CODE;
    e[2] = {1'b0, eom, ili, 1'b0, key};
    e[3] = info[31:24];
    e[4] = info[23:16];
    e[5] = info[15:8];
    e[6] = info[7:0];
    e[7] = 8'h0A;
    e[12] = asc;
    e[13] = ascq;
    for (int n = 0; n < 18; n++) begin
      rdck("sense byte", `SST_OFF_SENSE + 8'(4 * n), {24'h0, e[n]});
    end
  endtask

  task automatic cond(input int i);
    @(posedge sys_clk);
    condValid <= 1'b1;
    condCode  <= sst_cond_t'(i[4:0]);
    @(posedge sys_clk);
    condValid <= 1'b0;
  endtask

  task automatic diag(input logic st, pf, ofl, input logic [15:0] len,
                      input int lat, input logic chk);
    int n;
    @(posedge sys_clk);
    sendReq  <= 1'b1;
    selfTest <= st;
    pageFmt  <= pf;
    offLine  <= ofl;
    listLen  <= len;
    @(posedge sys_clk);
    sendReq <= 1'b0;
    @(posedge sys_clk);
    #1 n = 0;
    while (diagDone !== 1'b1) begin
      if (n == 40) begin
        fails++;
        close_out();
      end
      @(posedge sys_clk);
      #1 n++;
    end
    check("diag latency", 32'(n), 32'(lat));
    check("diag check", {31'h0, diagCheck}, {31'h0, chk});
  endtask

  initial begin
    {rst, regWr, regRd, condValid, readDone, windowEnd, hwFault} = 7'h7F - 7'h3F;
    {dblFeedPin, interlockPin, sendReq, selfTest, pageFmt, offLine} = 6'h00;
    {regAddr, regWdata, reqLen, actLen, listLen} = '0;
    condCode = SST_C_NOTREADY;
    fails = 0;
    cmpCount = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdck("summary", `SST_OFF_SUMMARY, 32'h0106_0000);
    rdck("ctrl", `SST_OFF_CTRL, 32'h0000_0000);
    rdck("mask", `SST_OFF_MASK, 32'h0000_0000);
    rdck("unmapped", 8'h10, 32'h0000_0000);
    senseCk(4'h6, 8'h00, 8'h00, 1'b0, 1'b0, 32'h0000_0000);
    wr(`SST_OFF_MASK, 32'h0000_0001);
    rd(`SST_OFF_STAT, got);
    for (int i = 0; i < 25; i++) begin
      cond(i);
      @(posedge sys_clk);
      #1 check("irq set", {31'h0, irq}, 32'h0000_0001);
      rdck("status", `SST_OFF_STAT, 32'h0000_0001);
      rdck("summary", `SST_OFF_SUMMARY, {8'h01, 4'h0, codeTbl[i]});
      rdck("sense end", `SST_OFF_SENSE + 8'h44, 32'h0000_0000);
      check("irq clear", {31'h0, irq}, 32'h0000_0000);
    end
    wr(`SST_OFF_MASK, 32'h0000_0000);
    cond(23);
    repeat (2) @(posedge sys_clk);
    #1 check("irq masked", {31'h0, irq}, 32'h0000_0000);
    rdck("status", `SST_OFF_STAT, 32'h0000_0001);
    rd(`SST_OFF_SENSE + 8'h44, got);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      readDone <= 1'b1;
      reqLen   <= lenA[i];
      actLen   <= lenB[i];
      @(posedge sys_clk);
      readDone <= 1'b0;
      senseCk(4'h0, 8'h00, 8'h00, 1'b0, lenA[i] != lenB[i], lenA[i] - lenB[i]);
    end
    @(posedge sys_clk);
    windowEnd <= 1'b1;
    @(posedge sys_clk);
    windowEnd <= 1'b0;
    rd(`SST_OFF_STAT, got);
    check("window status", got & 32'h0000_0004, 32'h0000_0004);
    senseCk(4'h0, 8'h00, 8'h00, 1'b1, 1'b0, 32'h0000_0000);
    dblFeedPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdck("feed off", `SST_OFF_SUMMARY, 32'h0000_0000);
    wr(`SST_OFF_CTRL, 32'h0000_0001);
    rdck("ctrl", `SST_OFF_CTRL, 32'h0000_0001);
    rdck("double feed", `SST_OFF_SUMMARY, 32'h0103_8001);
    dblFeedPin <= 1'b0;
    wr(`SST_OFF_CTRL, 32'h0000_0000);
    wr(8'h20, 32'h0000_0001);
    rdck("ctrl", `SST_OFF_CTRL, 32'h0000_0000);
    rd(`SST_OFF_SENSE + 8'h44, got);
    interlockPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdck("interlock", `SST_OFF_SUMMARY, 32'h0102_8001);
    rd(`SST_OFF_STAT, got);
    diag(1'b1, 1'b0, 1'b0, 16'h0000, STC, 1'b0);
    rdck("diag status", `SST_OFF_STAT, 32'h0000_0002);
    diag(1'b1, 1'b1, 1'b1, 16'h0000, STC, 1'b0);
    hwFault <= 1'b1;
    diag(1'b1, 1'b0, 1'b0, 16'h0000, STC, 1'b1);
    rdck("fault sense", `SST_OFF_SUMMARY, 32'h0104_4400);
    hwFault <= 1'b0;
    diag(1'b0, 1'b0, 1'b0, 16'h0000, 0, 1'b1);
    rdck("bad block", `SST_OFF_SUMMARY, 32'h0105_2400);
    diag(1'b1, 1'b0, 1'b0, 16'h0001, 0, 1'b1);
    rdck("bad length", `SST_OFF_SUMMARY, 32'h0105_2400);
    close_out();
  end
endmodule // scsi_sense_and_selftest_bench
`default_nettype wire
